// *** logic/lsec_regs.vh ***
// Register map, field positions, codes and timing constants
`ifndef LSEC_REGS_VH
`define LSEC_REGS_VH

// ----------------------------------------
// Register addresses
// ----------------------------------------
`define LSEC_A_CTRL 8'h00
`define LSEC_A_PWM_FIRST 8'h16
`define LSEC_A_PWM_LAST 8'h1e
`define LSEC_A_PC1 8'h37
`define LSEC_A_PC3 8'h39
`define LSEC_A_MAP1_HI 8'h70
`define LSEC_A_MAP1_LO 8'h71
`define LSEC_A_MAP2_HI 8'h72
`define LSEC_A_MAP2_LO 8'h73
`define LSEC_A_MAP3_HI 8'h74
`define LSEC_A_MAP3_LO 8'h75
`define LSEC_A_GAIN 8'h76

// ----------------------------------------
// Field positions
// ----------------------------------------
`define LSEC_CHIP_EN_BIT 6
`define LSEC_EXEC1_HI 5
`define LSEC_EXEC1_LO 4
`define LSEC_THR_HI 7
`define LSEC_THR_LO 6
`define LSEC_ADAPT_BIT 5
`define LSEC_TMR_HI 4
`define LSEC_TMR_LO 3
`define LSEC_FORCE_BIT 2

// ----------------------------------------
// Reset values and codes
// ----------------------------------------
`define LSEC_RST_BYTE 8'h00
`define LSEC_RST_MAP 9'h000
`define LSEC_EXEC_HOLD 2'b00
`define LSEC_EXEC_STEP 2'b01
`define LSEC_EXEC_FREE 2'b10
`define LSEC_EXEC_ONCE 2'b11
`define LSEC_MODE_LOAD 2'b01
`define LSEC_MODE_RUN 2'b10
`define LSEC_MODE_HALT 2'b11
`define LSEC_TMR_5 2'b00
`define LSEC_TMR_10 2'b01
`define LSEC_TMR_50 2'b10
`define LSEC_THR_400 9'h190
`define LSEC_THR_300 9'h12c
`define LSEC_THR_200 9'h0c8
`define LSEC_THR_100 9'h064
`define LSEC_PC_LIMIT 7'h5f

// ----------------------------------------
// Timing
// ----------------------------------------
`define LSEC_CLK_HZ 10000000
`define LSEC_T5_MS 5
`define LSEC_T10_MS 10
`define LSEC_T50_MS 50

`endif

// *** logic/lsec_i2c_slave.v ***
// Serial bus slave: byte transfers into register pointer, writes and reads
`timescale 1ns/10ps
`default_nettype none
`include "lsec_regs.vh"
module lsec_i2c_slave #(
    parameter [6:0] DEV_ADDR = 7'h32
) (
    input wire clk,
    input wire rst,
    input wire scl_in,
    input wire sda_in,
    output reg sda_out,
    output reg sda_oe,
    output reg [7:0] ptr_reg,
    output reg wr_en_reg,
    output reg [7:0] wr_data_reg,
    input wire [7:0] rd_data
);
    localparam [2:0] S_IDLE = 3'd0;
    localparam [2:0] S_ADDR = 3'd1;
    localparam [2:0] S_ACKA = 3'd2;
    localparam [2:0] S_WDAT = 3'd3;
    localparam [2:0] S_ACKW = 3'd4;
    localparam [2:0] S_RDAT = 3'd5;
    localparam [2:0] S_ACKR = 3'd6;

    // ----------------------------------------
    // Input synchronisers, change taken when stages two and three agree
    // ----------------------------------------
    reg [2:0] scl_sync_reg;
    reg [2:0] sda_sync_reg;
    reg scl_reg;
    reg sda_reg;
    always @(posedge clk) begin
        scl_sync_reg <= {scl_sync_reg[1:0], scl_in};
        sda_sync_reg <= {sda_sync_reg[1:0], sda_in};
        if (rst) begin
            scl_reg <= 1'b1;
            sda_reg <= 1'b1;
        end else begin
            if (scl_sync_reg[1] == scl_sync_reg[2])
                scl_reg <= scl_sync_reg[2];
            if (sda_sync_reg[1] == sda_sync_reg[2])
                sda_reg <= sda_sync_reg[2];
        end
    end
    wire scl_f = scl_sync_reg[1] == scl_sync_reg[2] ? scl_sync_reg[2] : scl_reg;
    wire sda_f = sda_sync_reg[1] == sda_sync_reg[2] ? sda_sync_reg[2] : sda_reg;
    wire scl_rise = scl_f && !scl_reg;
    wire scl_fall = !scl_f && scl_reg;
    wire start_cond = scl_reg && scl_f && sda_reg && !sda_f;
    wire stop_cond = scl_reg && scl_f && !sda_reg && sda_f;

    // ----------------------------------------
    // Byte engine
    // ----------------------------------------
    reg [2:0] st_reg;
    reg [2:0] bit_reg;
    reg [7:0] sh_reg;
    reg full_reg;
    reg first_reg;
    reg nack_reg;
    always @(posedge clk) begin
        if (rst) begin
            st_reg <= S_IDLE;
            bit_reg <= 3'd7;
            sh_reg <= `LSEC_RST_BYTE;
            full_reg <= 1'b0;
            first_reg <= 1'b0;
            nack_reg <= 1'b0;
            sda_out <= 1'b0;
            sda_oe <= 1'b0;
            ptr_reg <= `LSEC_RST_BYTE;
            wr_en_reg <= 1'b0;
            wr_data_reg <= `LSEC_RST_BYTE;
        end else begin
            wr_en_reg <= 1'b0;
            sda_out <= 1'b0;
            if (start_cond) begin
                st_reg <= S_ADDR;
                bit_reg <= 3'd7;
                full_reg <= 1'b0;
                sda_oe <= 1'b0;
            end else if (stop_cond) begin
                st_reg <= S_IDLE;
                sda_oe <= 1'b0;
            end else if (scl_rise) begin
                if (st_reg == S_ADDR || st_reg == S_WDAT) begin
                    sh_reg <= {sh_reg[6:0], sda_f};
                    bit_reg <= bit_reg - 3'd1;
                    full_reg <= (bit_reg == 3'd0);
                end
                if (st_reg == S_ACKR)
                    nack_reg <= sda_f;
            end else if (scl_fall) begin
                case (st_reg)
                    S_ADDR: begin
                        if (full_reg) begin
                            if (sh_reg[7:1] == DEV_ADDR) begin
                                st_reg <= S_ACKA;
                                sda_oe <= 1'b1;
                            end else begin
                                st_reg <= S_IDLE;
                            end
                        end
                    end
                    S_ACKA: begin
                        bit_reg <= 3'd7;
                        full_reg <= 1'b0;
                        if (sh_reg[0]) begin
                            st_reg <= S_RDAT;
                            sh_reg <= rd_data;
                            sda_oe <= ~rd_data[7];
                        end else begin
                            st_reg <= S_WDAT;
                            first_reg <= 1'b1;
                            sda_oe <= 1'b0;
                        end
                    end
                    S_WDAT: begin
                        if (full_reg) begin
                            if (first_reg) begin
                                ptr_reg <= sh_reg;
                            end else begin
                                wr_en_reg <= 1'b1;
                                wr_data_reg <= sh_reg;
                            end
                            st_reg <= S_ACKW;
                            sda_oe <= 1'b1;
                        end
                    end
                    S_ACKW: begin
                        // Pointer moves after the strobe so the write lands at the old one
                        if (!first_reg)
                            ptr_reg <= ptr_reg + 8'd1;
                        first_reg <= 1'b0;
                        st_reg <= S_WDAT;
                        bit_reg <= 3'd7;
                        full_reg <= 1'b0;
                        sda_oe <= 1'b0;
                    end
                    S_RDAT: begin
                        if (bit_reg == 3'd0) begin
                            st_reg <= S_ACKR;
                            sda_oe <= 1'b0;
                            ptr_reg <= ptr_reg + 8'd1;
                        end else begin
                            sh_reg <= {sh_reg[6:0], 1'b0};
                            sda_oe <= ~sh_reg[6];
                            bit_reg <= bit_reg - 3'd1;
                        end
                    end
                    S_ACKR: begin
                        if (nack_reg) begin
                            st_reg <= S_IDLE;
                        end else begin
                            st_reg <= S_RDAT;
                            bit_reg <= 3'd7;
                            sh_reg <= rd_data;
                            sda_oe <= ~rd_data[7];
                        end
                    end
                    default: st_reg <= S_IDLE;
                endcase
            end
        end
    end
endmodule
`default_nettype wire

// *** logic/lsec_seq_engine.v ***
// Engine one execution control and program counter
`timescale 1ns/10ps
`default_nettype none
`include "lsec_regs.vh"
module lsec_seq_engine #(
    parameter [7:0] INSTR_CYC = 8'h04
) (
    input wire clk,
    input wire rst,
    input wire powered,
    input wire [1:0] run_field,
    input wire [1:0] op_mode,
    input wire pc_wr,
    input wire [6:0] pc_wdata,
    output reg [6:0] pc_reg,
    output reg busy_reg,
    output reg exec_clr_reg
);
    reg [7:0] cnt_reg;
    reg [1:0] kind_reg;
    wire run_ok = powered && op_mode == `LSEC_MODE_RUN;
    wire [6:0] pc_inc = (pc_reg == `LSEC_PC_LIMIT) ? 7'h00 : pc_reg + 7'h01;

    always @(posedge clk) begin
        if (rst) begin
            pc_reg <= 7'h00;
            busy_reg <= 1'b0;
            exec_clr_reg <= 1'b0;
            cnt_reg <= 8'h00;
            kind_reg <= `LSEC_EXEC_HOLD;
        end else begin
            exec_clr_reg <= 1'b0;
            if (!powered || op_mode == `LSEC_MODE_HALT) begin
                busy_reg <= 1'b0;
            end else if (op_mode == `LSEC_MODE_LOAD) begin
                busy_reg <= 1'b0;
                pc_reg <= 7'h00;
            end else if (busy_reg) begin
                if (cnt_reg == 8'h01) begin
                    case (kind_reg)
                        `LSEC_EXEC_STEP: begin
                            pc_reg <= pc_inc;
                            exec_clr_reg <= 1'b1;
                            busy_reg <= 1'b0;
                        end
                        `LSEC_EXEC_ONCE: begin
                            exec_clr_reg <= 1'b1;
                            busy_reg <= 1'b0;
                        end
                        default: begin
                            pc_reg <= pc_inc;
                            // Hold lets the running instruction end first
                            busy_reg <= run_ok && run_field == `LSEC_EXEC_FREE;
                            cnt_reg <= INSTR_CYC;
                        end
                    endcase
                end else begin
                    cnt_reg <= cnt_reg - 8'h01;
                end
            end else if (run_ok && run_field != `LSEC_EXEC_HOLD && !exec_clr_reg) begin
                busy_reg <= 1'b1;
                kind_reg <= run_field;
                cnt_reg <= INSTR_CYC;
            end else if (pc_wr) begin
                pc_reg <= pc_wdata;
            end
        end
    end
endmodule
`default_nettype wire

// *** logic/lsec_top.v ***
// LED sequencer control register slice with serial bus access
`timescale 1ns/10ps
`default_nettype none
`include "lsec_regs.vh"
module lsec_top #(
    parameter [6:0] DEV_ADDR = 7'h32,
    parameter [31:0] T5_CYC = `LSEC_T5_MS * (`LSEC_CLK_HZ / 1000),
    parameter [31:0] T10_CYC = `LSEC_T10_MS * (`LSEC_CLK_HZ / 1000),
    parameter [31:0] T50_CYC = `LSEC_T50_MS * (`LSEC_CLK_HZ / 1000),
    parameter [15:0] STARTUP_CYC = 16'h0010,
    parameter [7:0] INSTR_CYC = 8'h04
) (
    input wire clk,
    input wire rst,
    input wire scl_in,
    input wire sda_in,
    output wire sda_out,
    output wire sda_oe,
    input wire [8:0] seq1_map,
    input wire [8:0] seq2_map,
    input wire [8:0] seq3_map,
    input wire [1:0] sequencer_one_op_mode,
    input wire pump_at_boost,
    output reg chip_powered_reg,
    output reg [1:0] sequencer_one_run_field,
    output reg [8:0] threshold_mv_reg,
    output reg adaptive_level_enable,
    output reg [1:0] timer_sel_reg,
    output reg force_unity_gain,
    output reg pump_unity_req_reg,
    output wire [6:0] seq1_pc,
    output wire seq1_busy
);
    // Power sequencing states
    localparam [1:0] P_OFF = 2'd0;
    localparam [1:0] P_START = 2'd1;
    localparam [1:0] P_ON = 2'd2;

    // ----------------------------------------
    // Bus slave
    // ----------------------------------------
    wire [7:0] ptr;
    wire wr_en;
    wire [7:0] wr_data;
    reg [7:0] rd_data;

    // Pointer and write strobe come from flops, one clock wide
    lsec_i2c_slave #(
        .DEV_ADDR(DEV_ADDR)
    ) u_bus (
        .clk(clk),
        .rst(rst),
        .scl_in(scl_in),
        .sda_in(sda_in),
        .sda_out(sda_out),
        .sda_oe(sda_oe),
        .ptr_reg(ptr),
        .wr_en_reg(wr_en),
        .wr_data_reg(wr_data),
        .rd_data(rd_data)
    );

    // ----------------------------------------
    // Control register
    // ----------------------------------------
    reg chip_en_reg;
    // Engines two and three only keep their run fields
    reg [3:0] exec23_reg;
    wire exec_clr;
    wire ctrl_wr = wr_en && ptr == `LSEC_A_CTRL;
    // Counter access needs hold and no instruction in flight
    wire in_hold = sequencer_one_run_field == `LSEC_EXEC_HOLD && !seq1_busy;

    always @(posedge clk) begin
        if (rst) begin
            chip_en_reg <= 1'b0;
            sequencer_one_run_field <= `LSEC_EXEC_HOLD;
            exec23_reg <= 4'h0;
        end else begin
            // Power enable lands even in standby
            if (ctrl_wr)
                chip_en_reg <= wr_data[`LSEC_CHIP_EN_BIT];
            // Host write beats the engine's return to hold
            if (ctrl_wr && chip_en_reg) begin
                sequencer_one_run_field <= wr_data[`LSEC_EXEC1_HI:`LSEC_EXEC1_LO];
                exec23_reg <= wr_data[3:0];
            end else if (exec_clr) begin
                sequencer_one_run_field <= `LSEC_EXEC_HOLD;
            end
        end
    end

    // ----------------------------------------
    // Start-up sequence
    // ----------------------------------------
    reg [1:0] pwr_st_reg;
    reg [15:0] pwr_cnt_reg;
    always @(posedge clk) begin
        if (rst) begin
            pwr_st_reg <= P_OFF;
            pwr_cnt_reg <= 16'h0000;
            chip_powered_reg <= 1'b0;
        end else begin
            case (pwr_st_reg)
                P_OFF: begin
                    chip_powered_reg <= 1'b0;
                    if (chip_en_reg) begin
                        pwr_st_reg <= P_START;
                        pwr_cnt_reg <= STARTUP_CYC;
                    end
                end
                // Dropping the enable aborts start-up at once
                P_START: begin
                    if (!chip_en_reg) begin
                        pwr_st_reg <= P_OFF;
                    end else if (pwr_cnt_reg <= 16'h0001) begin
                        pwr_st_reg <= P_ON;
                        chip_powered_reg <= 1'b1;
                    end else begin
                        pwr_cnt_reg <= pwr_cnt_reg - 16'h0001;
                    end
                end
                P_ON: begin
                    if (!chip_en_reg) begin
                        pwr_st_reg <= P_OFF;
                        chip_powered_reg <= 1'b0;
                    end
                end
                default: pwr_st_reg <= P_OFF;
            endcase
        end
    end

    // ----------------------------------------
    // Engine one
    // ----------------------------------------
    // Counter write is also dropped while an instruction is in flight
    wire pc_wr = wr_en && ptr == `LSEC_A_PC1 && chip_en_reg && in_hold;

    // Busy covers the whole instruction, not just its first clock
    lsec_seq_engine #(
        .INSTR_CYC(INSTR_CYC)
    ) u_eng (
        .clk(clk),
        .rst(rst),
        .powered(chip_powered_reg),
        .run_field(sequencer_one_run_field),
        .op_mode(sequencer_one_op_mode),
        .pc_wr(pc_wr),
        .pc_wdata(wr_data[6:0]),
        .pc_reg(seq1_pc),
        .busy_reg(seq1_busy),
        .exec_clr_reg(exec_clr)
    );

    // ----------------------------------------
    // Mapping registers, fed by the engines only
    // ----------------------------------------
    // No write path exists, so host writes fall away
    reg [8:0] map_reg [0:2];
    wire [26:0] map_in = {seq3_map, seq2_map, seq1_map};
    genvar gi;
    generate
        for (gi = 0; gi < 3; gi = gi + 1) begin : g_map
            always @(posedge clk) begin
                if (rst)
                    map_reg[gi] <= `LSEC_RST_MAP;
                else
                    map_reg[gi] <= map_in[gi*9 +: 9];
            end
        end
    endgenerate

    // ----------------------------------------
    // Gain change configuration
    // ----------------------------------------
    always @(posedge clk) begin
        if (rst) begin
            threshold_mv_reg <= `LSEC_THR_400;
            adaptive_level_enable <= 1'b0;
            timer_sel_reg <= `LSEC_TMR_5;
            force_unity_gain <= 1'b0;
        end else if (wr_en && ptr == `LSEC_A_GAIN) begin
            case (wr_data[`LSEC_THR_HI:`LSEC_THR_LO])
                2'b00: threshold_mv_reg <= `LSEC_THR_400;
                2'b01: threshold_mv_reg <= `LSEC_THR_300;
                2'b10: threshold_mv_reg <= `LSEC_THR_200;
                default: threshold_mv_reg <= `LSEC_THR_100;
            endcase
            adaptive_level_enable <= wr_data[`LSEC_ADAPT_BIT];
            timer_sel_reg <= wr_data[`LSEC_TMR_HI:`LSEC_TMR_LO];
            force_unity_gain <= wr_data[`LSEC_FORCE_BIT];
        end
    end

    // Stored in millivolts; readback re-encodes the field
    reg [1:0] thr_code;
    always @* begin
        case (threshold_mv_reg)
            `LSEC_THR_400: thr_code = 2'b00;
            `LSEC_THR_300: thr_code = 2'b01;
            `LSEC_THR_200: thr_code = 2'b10;
            default: thr_code = 2'b11;
        endcase
    end

    // ----------------------------------------
    // Return-to-unity timer
    // ----------------------------------------
    reg [2:0] boost_sync_reg;
    reg boost_reg;
    reg [31:0] gt_cnt_reg;
    reg [31:0] gt_period;
    always @* begin
        case (timer_sel_reg)
            `LSEC_TMR_5: gt_period = T5_CYC;
            `LSEC_TMR_10: gt_period = T10_CYC;
            `LSEC_TMR_50: gt_period = T50_CYC;
            default: gt_period = 32'h0000_0000;
        endcase
    end
    // Infinite setting means the pump never drops back on its own
    wire gt_run = force_unity_gain && boost_reg && chip_powered_reg &&
        gt_period != 32'h0000_0000;

    always @(posedge clk) begin
        boost_sync_reg <= {boost_sync_reg[1:0], pump_at_boost};
        if (rst) begin
            boost_reg <= 1'b0;
            gt_cnt_reg <= 32'h0000_0000;
            pump_unity_req_reg <= 1'b0;
        end else begin
            if (boost_sync_reg[1] == boost_sync_reg[2])
                boost_reg <= boost_sync_reg[2];
            pump_unity_req_reg <= 1'b0;
            // Any arming condition dropping restarts the period
            if (!gt_run) begin
                gt_cnt_reg <= 32'h0000_0000;
            end else if (gt_cnt_reg >= gt_period - 32'h0000_0001) begin
                gt_cnt_reg <= 32'h0000_0000;
                pump_unity_req_reg <= 1'b1;
            end else begin
                gt_cnt_reg <= gt_cnt_reg + 32'h0000_0001;
            end
        end
    end

    // ----------------------------------------
    // Read data
    // ----------------------------------------
    always @* begin
        rd_data = `LSEC_RST_BYTE;
        case (ptr)
            `LSEC_A_CTRL: begin
                rd_data[`LSEC_CHIP_EN_BIT] = chip_en_reg;
                if (chip_en_reg) begin
                    rd_data[`LSEC_EXEC1_HI:`LSEC_EXEC1_LO] = sequencer_one_run_field;
                    rd_data[3:0] = exec23_reg;
                end
            end
            // Standby or an engine in flight reads as zero
            `LSEC_A_PC1: begin
                if (chip_en_reg && in_hold)
                    rd_data = {1'b0, seq1_pc};
            end
            `LSEC_A_MAP1_HI: rd_data = {7'h00, map_reg[0][8]};
            `LSEC_A_MAP1_LO: rd_data = map_reg[0][7:0];
            `LSEC_A_MAP2_HI: rd_data = {7'h00, map_reg[1][8]};
            `LSEC_A_MAP2_LO: rd_data = map_reg[1][7:0];
            `LSEC_A_MAP3_HI: rd_data = {7'h00, map_reg[2][8]};
            `LSEC_A_MAP3_LO: rd_data = map_reg[2][7:0];
            `LSEC_A_GAIN: begin
                rd_data[`LSEC_THR_HI:`LSEC_THR_LO] = thr_code;
                rd_data[`LSEC_ADAPT_BIT] = adaptive_level_enable;
                rd_data[`LSEC_TMR_HI:`LSEC_TMR_LO] = timer_sel_reg;
                rd_data[`LSEC_FORCE_BIT] = force_unity_gain;
            end
            default: rd_data = `LSEC_RST_BYTE;
        endcase
    end
endmodule
`default_nettype wire

// *** tb/lsec_checker.sv ***
// Port-level assertions for the control register slice
`timescale 1ns/10ps
`default_nettype none
module lsec_checker (
    input wire clk,
    input wire rst,
    input wire [1:0] sequencer_one_op_mode,
    input wire chip_powered_reg,
    input wire [1:0] sequencer_one_run_field,
    input wire [8:0] threshold_mv_reg,
    input wire [1:0] timer_sel_reg,
    input wire force_unity_gain,
    input wire pump_unity_req_reg,
    input wire [6:0] seq1_pc,
    input wire seq1_busy
);
    wire [1:0] fld = sequencer_one_run_field;
    wire run = sequencer_one_op_mode == 2'b10;
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    property p_thr; threshold_mv_reg inside {9'h190, 9'h12c, 9'h0c8, 9'h064}; endproperty
    a_thr: assert property (p_thr) else $error("threshold outside decode set");
    property p_free; $changed(seq1_pc) && $past(fld) == 2'b10 && $past(run) |->
        seq1_pc == ($past(seq1_pc) == 7'h5f ? 7'h00 : $past(seq1_pc) + 7'h01); endproperty
    a_free: assert property (p_free) else $error("counter step wrong");
    property p_once; $past(fld) == 2'b11 && $past(run) |-> $stable(seq1_pc); endproperty
    a_once: assert property (p_once) else $error("counter moved in once");
    property p_hold; fld == 2'b00 && !seq1_busy |=> !seq1_busy; endproperty
    a_hold: assert property (p_hold) else $error("busy in hold");
    property p_mode; !run && !seq1_busy |=> !seq1_busy; endproperty
    a_mode: assert property (p_mode) else $error("busy outside run mode");
    property p_sby; !chip_powered_reg && !seq1_busy |=> !seq1_busy; endproperty
    a_sby: assert property (p_sby) else $error("busy in standby");
    property p_sby_fld; !chip_powered_reg && !$past(chip_powered_reg) && !$past(seq1_busy)
        |-> $stable(fld); endproperty
    a_sby_fld: assert property (p_sby_fld) else $error("run field moved in standby");
    property p_pulse; pump_unity_req_reg |->
        $past(force_unity_gain) && $past(timer_sel_reg) != 2'b11; endproperty
    a_pulse: assert property (p_pulse) else $error("gain pulse not armed");
    c_step: cover property (fld == 2'b01 ##1 seq1_busy);
    c_wrap: cover property (seq1_pc == 7'h5f ##[1:8] seq1_pc == 7'h00);
    c_pulse: cover property (pump_unity_req_reg);
endmodule
bind lsec_top lsec_checker i_chk (.*);
`default_nettype wire

// *** tb/lsec_host.sv ***
// Open-drain serial host model issuing register writes and reads
`timescale 1ns/10ps
`default_nettype none
module lsec_host (
    input wire clk,
    input wire sda,
    output logic scl,
    output logic pull
);
    logic [6:0] dev = 7'h32;
    logic ack_seen;
    logic [7:0] q;
    initial begin
        scl = 1'b1;
        pull = 1'b0;
    end
    // Data moves mid-phase so it never races the clock edge
    task automatic ph(input logic s, input logic d);
        scl <= s;
        repeat (3) @(posedge clk);
        pull <= !d;
        repeat (4) @(posedge clk);
    endtask
    task automatic start();
        ph(1'b0, 1'b1);
        ph(1'b1, 1'b1);
        ph(1'b1, 1'b0);
    endtask
    task automatic stop();
        ph(1'b0, 1'b0);
        ph(1'b1, 1'b0);
        ph(1'b1, 1'b1);
    endtask
    task automatic xfer(input logic [8:0] d, output logic [8:0] r);
        for (int i = 8; i >= 0; i--) begin
            ph(1'b0, d[i]);
            ph(1'b1, d[i]);
            r[i] = sda;
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        logic [8:0] r;
        start();
        xfer({dev, 2'b01}, r);
        ack_seen = !r[0];
        xfer({a, 1'b1}, r);
        xfer({v, 1'b1}, r);
        stop();
    endtask
    task automatic rd(input logic [7:0] a);
        logic [8:0] r;
        start();
        xfer({dev, 2'b01}, r);
        xfer({a, 1'b1}, r);
        start();
        xfer({dev, 2'b11}, r);
        xfer(9'h1ff, r);
        q = r[8:1];
        stop();
    endtask
endmodule
`default_nettype wire

// *** tb/tb.sv ***
// Self-checking bench for the control register slice
`timescale 1ns/10ps
`default_nettype none
module tb;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [8:0] seq1_map = 9'h000;
    logic [8:0] seq2_map = 9'h000;
    logic [8:0] seq3_map = 9'h000;
    logic [1:0] sequencer_one_op_mode = 2'b00;
    logic pump_at_boost = 1'b0;
    logic [31:0] seed = 32'hc476389f;
    int err_count = 0;
    int num_checks = 0;
    wire scl_in, pull, sda_out, sda_oe, chip_powered_reg, adaptive_level_enable;
    wire force_unity_gain, pump_unity_req_reg, seq1_busy;
    wire [1:0] sequencer_one_run_field, timer_sel_reg;
    wire [8:0] threshold_mv_reg;
    wire [6:0] seq1_pc;
    wire sda_in = !pull && !(sda_oe && !sda_out);
    lsec_top #(.T5_CYC(32'h14), .T10_CYC(32'h28), .T50_CYC(32'h50)) i_dut (.*);
    lsec_host i_host (.clk(clk), .sda(sda_in), .scl(scl_in), .pull(pull));
    always #50 clk = !clk;
    task automatic chk(input string n, input logic [8:0] e, input logic [8:0] g);
        num_checks++;
        if (g !== e) begin
            err_count++;
            $display("[ERR] %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic rdchk(input string n, input logic [7:0] a, input logic [7:0] e);
        i_host.rd(a);
        chk(n, {1'b0, e}, {1'b0, i_host.q});
    endtask
    function automatic logic [7:0] mapx(input int i);
        logic [8:0] m;
        m = i < 2 ? seq1_map : i < 4 ? seq2_map : seq3_map;
        mapx = i[0] ? m[7:0] : {7'h00, m[8]};
    endfunction
    task automatic give_verdict();
        $display("checks %0d errors %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    initial begin
        repeat (80000) @(posedge clk);
        err_count++;
        give_verdict();
    end
    initial begin
        logic [7:0] v;
        int n;
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        repeat (8) @(posedge clk);
        rdchk("map1 low", 8'h71, 8'h00);
        rdchk("map2 high", 8'h72, 8'h00);
        seq1_map <= 9'($random(seed));
        seq2_map <= 9'($random(seed));
        seq3_map <= 9'($random(seed));
        for (int i = 0; i < 6; i++) begin
            i_host.wr(8'h70 + 8'(i), 8'hff);
            rdchk("map", 8'h70 + 8'(i), mapx(i));
        end
        for (int i = 0; i < 4; i++) begin
            v = {2'(i), 6'($random(seed))};
            i_host.wr(8'h76, v);
            rdchk("gain", 8'h76, v & 8'hfc);
            chk("thr", 9'h190 - 9'(i) * 9'h064, threshold_mv_reg);
            chk("bits", {5'h00, v[5:2]}, {5'h00, adaptive_level_enable, timer_sel_reg,
                force_unity_gain});
        end
        i_host.wr(8'h00, 8'h3f);
        rdchk("ctrl", 8'h00, 8'h00);
        chk("fld", 9'h000, {7'h00, sequencer_one_run_field});
        i_host.wr(8'h37, 8'h12);
        rdchk("pc", 8'h37, 8'h00);
        chk("pc", 9'h000, {2'b00, seq1_pc});
        i_host.dev = 7'h33;
        i_host.wr(8'h00, 8'h40);
        chk("ack", 9'h000, {8'h00, i_host.ack_seen});
        i_host.dev = 7'h32;
        i_host.wr(8'h00, 8'h40);
        repeat (20) @(posedge clk);
        chk("powered", 9'h001, {8'h00, chip_powered_reg});
        i_host.wr(8'h37, 8'h5c);
        rdchk("pc", 8'h37, 8'h5c);
        sequencer_one_op_mode <= 2'b10;
        i_host.wr(8'h00, 8'h50);
        rdchk("step", 8'h00, 8'h40);
        chk("pc", 9'h05d, {2'b00, seq1_pc});
        i_host.wr(8'h00, 8'h70);
        rdchk("once", 8'h00, 8'h40);
        chk("pc", 9'h05d, {2'b00, seq1_pc});
        i_host.wr(8'h00, 8'h60);
        i_host.wr(8'h00, 8'h40);
        chk("wrap", 9'h001, {8'h00, seq1_pc < 7'h5d});
        sequencer_one_op_mode <= 2'b11;
        i_host.wr(8'h00, 8'h50);
        rdchk("halted", 8'h00, 8'h50);
        pump_at_boost <= 1'b1;
        for (int j = 0; j < 2; j++) begin
            i_host.wr(8'h76, j ? 8'h1c : 8'h04);
            n = 0;
            repeat (100) @(posedge clk) n += int'(pump_unity_req_reg);
            chk("pulses", 9'h001, {8'h00, j ? n == 0 : n >= 4 && n <= 6});
        end
        give_verdict();
    end
endmodule
`default_nettype wire
